// *** hw/tlbm_core.sv ***
/*
 code and data translation buffers with software pinned slots and hardware
 cached entries, insert/purge sequencing, overlap purge, machine check and
 lookup, plus an AXI4-Lite slave for control and status.
 assumes the pipeline serializes around inserts and purges; region
 register contents arrive on region_id; one clock, synchronous reset.
*/
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
// Operation
// - a pinned translation stays until software overwrites its slot or purges it.
// - references covered by a pinned translation always hit, never walk or fault.
// - two translations overlap when some virtual address is mapped by both.
// - a same-side overlap involving a pinned translation raises machine check.
// - hardware never overwrites or purges a valid pinned slot itself.
// - free pinned slots may hold cached entries, removed when software inserts there.
// - top 3 virtual base bits pick region contents stored with the insert.
// - pinned insert purges overlapping same-side cached entries, maybe the other side.
// - same or overlapping translations in code and data pinned slots are accepted.
// - pinned purge takes base from one register, range from bits 7:2 of another.
// - top 3 purge base bits pick region contents used for matching.
// - pinned purge matches by address range, not by slot number.
// - pinned purge never removes other-side pinned entries, may remove other-side cache.
// - pinned purge touches only local buffers, no memory, no other processor.
// - cached entries fill from software inserts and an enabled walker; may vanish.
// - cache insert takes physical base from a register; hardware picks the entry.
// - cache insert purges overlapping same-side cached entries, maybe the other side.
// - at least 8 code and 8 data pinned slots and one cached entry each.
// - cached entries form a fully associative store not addressable by software.
`timescale 1ns/1ps
module tlbm_core
    import tlbm_pkg::*;
#(
    parameter int NUM_PIN = 8,
    parameter int NUM_CACHE = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [NUM_REGIONS-1:0][RID_W-1:0] region_id,
    input wire logic op_valid,
    output logic op_ready,
    input tlbm_op_t op,
    output logic op_done,
    output logic mcheck,
    input wire logic lk_valid,
    input tlbm_lookup_t lk,
    output logic lk_done,
    output tlbm_result_t lk_res,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int N = NUM_PIN + NUM_CACHE;
    localparam int IDX_W = $clog2(N);
    localparam int SLOT_W = $clog2(NUM_PIN);

    tlbm_entry_t ent [NUM_SIDES][N];
    logic [N-1:0] ovl [NUM_SIDES];
    logic [N-1:0] lhit [NUM_SIDES];
    logic [N-1:0] valid_v [NUM_SIDES];
    logic [N-1:0] pin_v [NUM_SIDES];
    logic [IDX_W-1:0] victim [NUM_SIDES];
    logic [IDX_W-1:0] rr [NUM_SIDES];
    logic walk_en;
    logic mcheck_sticky;
    logic [31:0] mcheck_cnt;

    // query taken from the operation
    logic is_purge;
    logic [VA_W-1:0] q_va;
    logic [PS_W-1:0] q_ps;
    logic [RID_W-1:0] q_rid;
    logic [RID_W-1:0] l_rid;
    logic [IDX_W-1:0] slot;
    logic fill_ok;
    logic op_fire;
    logic bad_ovl;

    assign op_ready = 1'b1; // one-cycle operations, so nothing to stall
    assign op_fire = op_valid;
    assign is_purge = (op.kind == TLBM_OP_PURGE_PIN);
    assign q_va = is_purge ? op.gr_a[VA_W-1:0] : op.fault_addr_reg;
    assign q_ps = is_purge ? op.gr_b[RANGE_HI:RANGE_LO]
                           : op.map_attr_reg[ATTR_PS_HI:ATTR_PS_LO];
    assign q_rid = region_id[q_va[VA_W-1 -: REGION_BITS]];
    assign l_rid = region_id[lk.va[VA_W-1 -: REGION_BITS]];
    assign slot = IDX_W'(op.gr_a[SLOT_W-1:0]);
    // walker fills only land while the walker is enabled
    assign fill_ok = (op.kind != TLBM_OP_WALK_FILL) || walk_en;

    // per entry: overlap against the op, hit against the lookup, update
    for (genvar s = 0; s < NUM_SIDES; s++) begin : g_side
        for (genvar i = 0; i < N; i++) begin : g_ent
            tlbm_match u_op_match (
                .ent(ent[s][i]),
                .q_va(q_va),
                .q_ps(q_ps),
                .q_rid(q_rid),
                .hit(ovl[s][i])
            );
            tlbm_match u_lk_match (
                .ent(ent[s][i]),
                .q_va(lk.va),
                .q_ps('0),
                .q_rid(l_rid),
                .hit(lhit[s][i])
            );
            assign valid_v[s][i] = ent[s][i].valid;
            assign pin_v[s][i] = ent[s][i].pin;

            logic own_side;
            logic is_tgt;
            assign own_side = (op.side == s[0]);
            always_comb begin
                is_tgt = 1'b0;
                if (own_side) begin
                    case (op.kind)
                        TLBM_OP_INS_PIN: is_tgt = (i < NUM_PIN) && (slot == IDX_W'(i));
                        TLBM_OP_INS_CACHE,
                        TLBM_OP_WALK_FILL: is_tgt = fill_ok && !bad_ovl
                                                    && (victim[s] == IDX_W'(i));
                        default: is_tgt = 1'b0;
                    endcase
                end
            end

            // whole update lands on one edge, so lookups never see half of it
            always_ff @(posedge clk) begin
                if (srst) begin
                    ent[s][i] <= '0;
                end else if (op_fire) begin
                    if (is_tgt) begin
                        // a pinned write also drops a cached entry parked here
                        ent[s][i].valid <= 1'b1;
                        ent[s][i].pin <= (op.kind == TLBM_OP_INS_PIN);
                        ent[s][i].va <= op.fault_addr_reg;
                        ent[s][i].ps <= op.map_attr_reg[ATTR_PS_HI:ATTR_PS_LO];
                        ent[s][i].key <= op.map_attr_reg[ATTR_KEY_HI:ATTR_KEY_LO];
                        ent[s][i].rid <= q_rid;
                        ent[s][i].pa <= op.gr_b[PA_W-1:0];
                    end else if (ovl[s][i]) begin
                        case (op.kind)
                            // range match, slot does not matter; pinned only own side
                            TLBM_OP_PURGE_PIN: begin
                                if (own_side || !ent[s][i].pin) begin
                                    ent[s][i].valid <= 1'b0;
                                end
                            end
                            // inserts drop cached overlaps on both sides; cache inserts and fills only when they land without machine check
                            TLBM_OP_INS_PIN: begin
                                if (!ent[s][i].pin) begin
                                    ent[s][i].valid <= 1'b0;
                                end
                            end
                            TLBM_OP_INS_CACHE,
                            TLBM_OP_WALK_FILL: begin
                                if (!ent[s][i].pin && fill_ok && !bad_ovl) begin
                                    ent[s][i].valid <= 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    // victim: free cached way, then a free pinned slot, then round robin
    always_comb begin
        for (int s = 0; s < NUM_SIDES; s++) begin
            victim[s] = rr[s];
            for (int i = N - 1; i >= 0; i--) begin
                if (!valid_v[s][i] && i < NUM_PIN) begin
                    victim[s] = IDX_W'(i);
                end
            end
            for (int i = N - 1; i >= NUM_PIN; i--) begin
                if (!valid_v[s][i]) begin
                    victim[s] = IDX_W'(i);
                end
            end
        end
    end

    // round robin never points at a pinned slot, so a valid pin is safe
    always_ff @(posedge clk) begin
        for (int s = 0; s < NUM_SIDES; s++) begin
            if (srst) begin
                rr[s] <= IDX_W'(NUM_PIN);
            end else if (op_fire && op.kind != TLBM_OP_INS_PIN && op.kind != TLBM_OP_PURGE_PIN
                         && op.side == s[0] && victim[s] == rr[s]) begin
                rr[s] <= (rr[s] == IDX_W'(N - 1)) ? IDX_W'(NUM_PIN) : rr[s] + IDX_W'(1);
            end
        end
    end

    // same-side overlap with a pinned entry other than the slot being rewritten
    always_comb begin
        logic [N-1:0] others;
        others = ovl[op.side] & pin_v[op.side];
        bad_ovl = 1'b0;
        case (op.kind)
            TLBM_OP_INS_PIN: begin
                others[slot] = 1'b0;
                bad_ovl = |others;
            end
            TLBM_OP_INS_CACHE: bad_ovl = |others;
            TLBM_OP_WALK_FILL: bad_ovl = walk_en && (|others);
            default: bad_ovl = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            op_done <= 1'b0;
            mcheck <= 1'b0;
        end else begin
            op_done <= op_fire;
            mcheck <= op_fire && bad_ovl;
        end
    end

    // lookup: first hit wins; a pinned hit never requests a walk
    always_ff @(posedge clk) begin
        if (srst) begin
            lk_done <= 1'b0;
            lk_res <= '0;
        end else begin
            lk_done <= lk_valid;
            if (lk_valid) begin
                lk_res <= '0;
                lk_res.walk <= walk_en;
                lk_res.fault <= !walk_en;
                for (int i = N - 1; i >= 0; i--) begin
                    if (lhit[lk.side][i]) begin
                        lk_res.hit <= 1'b1;
                        lk_res.walk <= 1'b0;
                        lk_res.fault <= 1'b0;
                        lk_res.pinned <= pin_v[lk.side][i];
                        lk_res.key <= ent[lk.side][i].key;
                        lk_res.pa <= page_pa(ent[lk.side][i], lk.va);
                    end
                end
            end
        end
    end

    function automatic logic [PA_W-1:0] page_pa(tlbm_entry_t e, logic [VA_W-1:0] va);
        logic [PA_W-1:0] m;
        m = (PA_W'(1) << e.ps) - PA_W'(1);
        return (e.pa & ~m) | (PA_W'(va) & m);
    endfunction

    // AXI4-Lite slave; address and data may arrive in either order
    logic aw_held, w_held;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic clr_mcheck;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign clr_mcheck = wr_go && aw_addr == REG_STATUS && w_strb[0]
                        && w_data[STATUS_MCHECK];

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == REG_CTRL || aw_addr == REG_STATUS)
                               ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            walk_en <= 1'b0;
        end else if (wr_go && aw_addr == REG_CTRL && w_strb[0]) begin
            walk_en <= w_data[CTRL_WALK_EN];
        end
    end

    // new machine check beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            mcheck_sticky <= 1'b0;
            mcheck_cnt <= '0;
        end else begin
            if (op_fire && bad_ovl) begin
                mcheck_sticky <= 1'b1;
                mcheck_cnt <= mcheck_cnt + 32'h00000001;
            end else if (clr_mcheck) begin
                mcheck_sticky <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
            case (s_axi_araddr)
                REG_CTRL: s_axi_rdata[CTRL_WALK_EN] <= walk_en;
                REG_STATUS: s_axi_rdata[STATUS_MCHECK] <= mcheck_sticky;
                REG_MCNT: s_axi_rdata <= mcheck_cnt;
                REG_VCODE: s_axi_rdata <= 32'(valid_v[SIDE_CODE]);
                REG_VDATA: s_axi_rdata <= 32'(valid_v[SIDE_DATA]);
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// *** hw/tlbm_pkg.sv ***
/*
 package for the pinned/cached translation block: widths, entry, operation
 and lookup carriers, register offsets and field positions.
 assumes a single processor clock domain.
*/
package tlbm_pkg;
    localparam int VA_W = 64;
    localparam int PA_W = 64;
    localparam int RID_W = 24;
    localparam int KEY_W = 24;
    localparam int PS_W = 6;
    localparam int REGION_BITS = 3;
    localparam int NUM_REGIONS = 8;
    localparam int NUM_SIDES = 2;
    // side encoding
    localparam logic SIDE_CODE = 1'b0;
    localparam logic SIDE_DATA = 1'b1;
    // purge range field in the second general register
    localparam int RANGE_LO = 2;
    localparam int RANGE_HI = 7;
    // attribute register layout
    localparam int ATTR_PS_LO = 2;
    localparam int ATTR_PS_HI = 7;
    localparam int ATTR_KEY_LO = 8;
    localparam int ATTR_KEY_HI = 31;
    // register map, byte addresses
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [AXI_AW-1:0] REG_MCNT = 8'h08;
    localparam logic [AXI_AW-1:0] REG_VCODE = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_VDATA = 8'h10;
    localparam int CTRL_WALK_EN = 0;
    localparam int STATUS_MCHECK = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        TLBM_OP_INS_PIN = 2'b00,
        TLBM_OP_INS_CACHE = 2'b01,
        TLBM_OP_PURGE_PIN = 2'b10,
        TLBM_OP_WALK_FILL = 2'b11
    } tlbm_kind_t;

    typedef struct packed {
        logic valid;
        logic pin;
        logic [VA_W-1:0] va;
        logic [PS_W-1:0] ps;
        logic [RID_W-1:0] rid;
        logic [KEY_W-1:0] key;
        logic [PA_W-1:0] pa;
    } tlbm_entry_t;

    typedef struct packed {
        tlbm_kind_t kind;
        logic side;
        logic [VA_W-1:0] fault_addr_reg;
        logic [31:0] map_attr_reg;
        logic [63:0] gr_a;
        logic [63:0] gr_b;
    } tlbm_op_t;

    typedef struct packed {
        logic side;
        logic [VA_W-1:0] va;
    } tlbm_lookup_t;

    typedef struct packed {
        logic hit;
        logic pinned;
        logic walk;
        logic fault;
        logic [PA_W-1:0] pa;
        logic [KEY_W-1:0] key;
    } tlbm_result_t;
endpackage

// *** hw/tlbm_match.sv ***
/*
 overlap test of one stored translation against a query range.
 assumes both ranges are naturally aligned powers of two in bytes.
*/
`timescale 1ns/1ps
module tlbm_match
    import tlbm_pkg::*;
(
    input tlbm_entry_t ent,
    input wire logic [VA_W-1:0] q_va,
    input wire logic [PS_W-1:0] q_ps,
    input wire logic [RID_W-1:0] q_rid,
    output logic hit
);
    logic [PS_W-1:0] big;
    logic [VA_W-1:0] mask;

    // aligned ranges share an address iff they agree above the larger size
    always_comb begin
        big = (ent.ps > q_ps) ? ent.ps : q_ps;
        mask = ~((VA_W'(1) << big) - VA_W'(1));
        hit = ent.valid && (ent.rid == q_rid) && (((ent.va ^ q_va) & mask) == '0);
    end
endmodule

// *** tb/tlbm_core_properties.sv ***
/*
 checker for tlbm_core: op, lookup and register bus timing.
 assumes one clock domain and the hand-over latencies of the core.
*/
`timescale 1ns/1ps
module tlbm_core_props
    import tlbm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic op_done,
    input wire logic mcheck,
    input wire logic lk_valid,
    input wire logic lk_done,
    input tlbm_result_t lk_res,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_done;
        op_valid |=> op_done;
    endproperty
    a_done: assert property (p_done) else $error("op not completed");
    property p_nodone;
        !op_valid |=> !op_done;
    endproperty
    a_nodone: assert property (p_nodone) else $error("stray op done");
    property p_mc;
        mcheck |-> $past(op_valid);
    endproperty
    a_mc: assert property (p_mc) else $error("machine check without op");
    property p_lk;
        lk_valid |=> lk_done;
    endproperty
    a_lk: assert property (p_lk) else $error("lookup not answered");
    property p_hold;
        !lk_valid |=> $stable(lk_res);
    endproperty
    a_hold: assert property (p_hold) else $error("lookup result moved");
    property p_hit;
        lk_done && lk_res.hit |-> !lk_res.walk && !lk_res.fault;
    endproperty
    a_hit: assert property (p_hit) else $error("hit with walk or fault");
    property p_miss;
        lk_done && !lk_res.hit |-> lk_res.walk != lk_res.fault;
    endproperty
    a_miss: assert property (p_miss) else $error("miss outcome wrong");
    property p_bresp;
        s_wr |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response late");
    property p_rd;
        s_rd |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read data late");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    property p_ar;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar: assert property (p_ar) else $error("second read accepted");
endmodule

bind tlbm_core tlbm_core_props u_props (.*);

// *** tb/tlbm_pipe_model.sv ***
/*
 pipeline model: issues inserts, purges and lookups to the core.
 assumes single outstanding op; waits for done before the next.
*/
`timescale 1ns/1ps
module tlbm_pipe_model
    import tlbm_pkg::*;
(
    input wire logic clk,
    output logic op_valid,
    output tlbm_op_t op,
    input wire logic op_done,
    input wire logic mcheck,
    output logic lk_valid,
    output tlbm_lookup_t lk,
    input wire logic lk_done,
    input tlbm_result_t lk_res,
    output logic hung
);
    int idle = 0;
    initial begin
        op_valid = 1'b0;
        op = '0;
        lk_valid = 1'b0;
        lk = '0;
        hung = 1'b0;
    end
    task automatic issue(input tlbm_kind_t k, input logic sd, input logic [63:0] va, a, b,
                         output logic mc);
        int n;
        repeat (idle + 1) @(posedge clk);
        // collect_enable_bit taken as cleared and serialized already
        op_valid <= 1'b1;
        op <= '{kind: k, side: sd, fault_addr_reg: va, map_attr_reg: 32'h0000_0030,
                gr_a: a, gr_b: b};
        @(posedge clk);
        op_valid <= 1'b0;
        op <= ~op;
        // serialize: nothing else until done
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (op_done) break;
        end
        hung <= hung | (n == 20);
        mc = mcheck;
    endtask
    task automatic look(input logic sd, input logic [63:0] va, output tlbm_result_t r);
        int n;
        @(posedge clk);
        lk_valid <= 1'b1;
        lk <= '{side: sd, va: va};
        @(posedge clk);
        lk_valid <= 1'b0;
        lk <= ~lk;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (lk_done) break;
        end
        hung <= hung | (n == 20);
        r = lk_res;
    endtask
endmodule

// *** tb/tlbm_core_bench.sv ***
/*
 bench for tlbm_core: register bus tasks plus pipeline model calls.
 assumes the core answers ops and lookups one cycle after they are taken.
*/
`timescale 1ns/1ps
module tlbm_core_bench
    import tlbm_pkg::*;
;
    localparam logic [63:0] VA_A = 64'h4000_0000_0001_0000;
    localparam logic [63:0] VA_B = 64'h4000_0000_0002_0000;
    localparam logic [63:0] VA_C = 64'h2000_0000_0000_0000;
    localparam logic [63:0] VA_D = 64'h6000_0000_0005_0000;
    localparam logic [63:0] PA1 = 64'h0000_0000_0800_0000;
    localparam logic [63:0] PA2 = 64'h0000_0000_0900_0000;
    localparam logic [63:0] PA3 = 64'h0000_0000_0A00_0000;
    localparam logic [3:0] H_PIN = 4'hC;
    localparam logic [3:0] H_CACHE = 4'h8;
    localparam logic [3:0] M_WALK = 4'h2;
    localparam logic [3:0] M_FLT = 4'h1;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [NUM_REGIONS-1:0][RID_W-1:0] region_id;
    logic op_valid, op_ready, op_done, mcheck, lk_valid, lk_done, hung;
    tlbm_op_t op;
    tlbm_lookup_t lk;
    tlbm_result_t lk_res;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt = 0;
    int num_checks = 0;
    tlbm_core dut (.*);
    tlbm_pipe_model pipe (.clk(clk), .op_valid(op_valid), .op(op), .op_done(op_done),
        .mcheck(mcheck), .lk_valid(lk_valid), .lk(lk), .lk_done(lk_done), .lk_res(lk_res),
        .hung(hung));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge hung) begin
        error_cnt++;
        wrap_up();
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) begin
            error_cnt++;
            wrap_up();
        end
        s_axi_bready <= 1'b0;
        check(64'(s_axi_bresp), 64'(er));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) begin
            error_cnt++;
            wrap_up();
        end
        // data taken at the edge rvalid is seen, then rready drops
        s_axi_rready <= 1'b0;
        check(64'({s_axi_rresp, s_axi_rdata}), 64'({er, ed}));
    endtask
    task automatic opc(input tlbm_kind_t k, input logic sd, input logic [63:0] va, a, b,
                       input logic emc);
        logic mc;
        pipe.issue(k, sd, va, a, b, mc);
        check(64'(mc), 64'(emc));
    endtask
    task automatic lkc(input logic sd, input logic [63:0] va, input logic [3:0] e,
                       input logic [63:0] pa);
        tlbm_result_t r;
        pipe.look(sd, va, r);
        check(64'({r.hit, r.pinned, r.walk, r.fault}), 64'(e));
        if (e[3]) check(r.pa, pa);
    endtask
    initial begin
        logic [7:0] regs [5];
        regs = '{REG_CTRL, REG_STATUS, REG_MCNT, REG_VCODE, REG_VDATA};
        for (int i = 0; i < NUM_REGIONS; i++) region_id[i] = 24'(16'h0100 + i);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) axi_rd(regs[i], 32'h0, RESP_OKAY);
        axi_rd(8'h20, 32'h0, RESP_SLVERR);
        axi_wr(REG_VCODE, 32'hF, RESP_SLVERR);
        lkc(SIDE_CODE, VA_A, M_FLT, PA1);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        opc(TLBM_OP_INS_PIN, SIDE_CODE, VA_A, 64'h0, PA1, 1'b0);
        lkc(SIDE_CODE, VA_A, H_PIN, PA1);
        axi_rd(REG_VCODE, 32'h1, RESP_OKAY);
        opc(TLBM_OP_INS_PIN, SIDE_DATA, VA_A, 64'h0, PA1, 1'b0);
        lkc(SIDE_DATA, VA_A, H_PIN, PA1);
        opc(TLBM_OP_INS_PIN, SIDE_CODE, VA_A, 64'h1, PA2, 1'b1);
        axi_rd(REG_STATUS, 32'h1, RESP_OKAY);
        axi_rd(REG_MCNT, 32'h1, RESP_OKAY);
        axi_wr(REG_STATUS, 32'h1, RESP_OKAY);
        axi_rd(REG_STATUS, 32'h0, RESP_OKAY);
        opc(TLBM_OP_INS_CACHE, SIDE_CODE, VA_B, 64'h0, PA1, 1'b0);
        lkc(SIDE_CODE, VA_B, H_CACHE, PA1);
        opc(TLBM_OP_INS_CACHE, SIDE_CODE, VA_B, 64'h0, PA2, 1'b0);
        lkc(SIDE_CODE, VA_B, H_CACHE, PA2);
        opc(TLBM_OP_INS_CACHE, SIDE_CODE, VA_A, 64'h0, PA3, 1'b1);
        lkc(SIDE_CODE, VA_A, H_PIN, PA1);
        opc(TLBM_OP_INS_PIN, SIDE_CODE, VA_B, 64'h2, PA3, 1'b0);
        lkc(SIDE_CODE, VA_B, H_PIN, PA3);
        axi_rd(REG_VCODE, 32'h7, RESP_OKAY);
        pipe.idle = 2;
        for (int i = 0; i < 12; i++) opc(TLBM_OP_INS_CACHE, SIDE_DATA, VA_C + (64'(i) << 12),
            64'h0, PA2, 1'b0);
        pipe.idle = 0;
        lkc(SIDE_DATA, VA_C + 64'hB000, H_CACHE, PA2);
        opc(TLBM_OP_INS_PIN, SIDE_DATA, VA_D, 64'h7, PA3, 1'b0);
        lkc(SIDE_DATA, VA_D, H_PIN, PA3);
        lkc(SIDE_DATA, VA_C + 64'hA000, M_WALK, PA1);
        lkc(SIDE_DATA, VA_A, H_PIN, PA1);
        opc(TLBM_OP_WALK_FILL, SIDE_CODE, VA_D, 64'h0, PA1, 1'b0);
        lkc(SIDE_CODE, VA_D, H_CACHE, PA1);
        opc(TLBM_OP_PURGE_PIN, SIDE_CODE, VA_A, VA_A, 64'h30, 1'b0);
        lkc(SIDE_CODE, VA_A, M_WALK, PA1);
        lkc(SIDE_CODE, VA_B, H_PIN, PA3);
        lkc(SIDE_DATA, VA_A, H_PIN, PA1);
        region_id[2] <= 24'hABCDEF;
        lkc(SIDE_DATA, VA_A, M_WALK, PA1);
        opc(TLBM_OP_PURGE_PIN, SIDE_DATA, VA_A, VA_A, 64'h30, 1'b0);
        region_id[2] <= 24'h000102;
        lkc(SIDE_DATA, VA_A, H_PIN, PA1);
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        lkc(SIDE_CODE, VA_A, M_FLT, PA1);
        wrap_up();
    end
endmodule
